/* File: hdl/debug_event_control.sv */
// debug event control: control word, two data watch addresses, event gating.
// assumes the pipeline inputs are on ref_clk_i and are one-cycle pulses,
// and that the special register port gives one access per request cycle.
//
// Function
// - control bit 0 enables external debug mode
// - control bit 1 enables internal debug mode
// - bits 2:3 request none/core/chip/system reset
// - bit 4 enables completion events, trace-gated
// - bit 5 enables taken branch events, trace-gated
// - bit 6 interrupt events; critical blocked internally
// - bit 7 enables trap events
// - bits 8-11 enable instruction comparators 1-4
// - bits 12-15 enable data watch load/store events
// - bit 16 return events; critical returns trace-gated
// - bit 31 freezes timers while status set
// - watch registers hold full 32-bit byte address
// - control word at 0x134, supervisor only
// - watch registers at 0x13C, 0x13D, supervisor only
`default_nettype none

module debug_event_control
    import debug_event_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // special register port
    input wire logic spr_req_i,
    input wire logic spr_write_i,
    input wire logic [9:0] spr_num_i,
    input wire logic [31:0] spr_wdata_i,
    input wire logic supervisor_i,
    output logic spr_ack_o,
    output logic spr_denied_o,
    output logic [31:0] spr_rdata_o,
    // pipeline side
    input wire logic machine_state_trace_allow_i,
    input wire logic debug_wait_i,
    input wire logic instr_complete_i,
    input wire logic branch_taken_i,
    input wire logic interrupt_i,
    input wire logic interrupt_critical_i,
    input wire logic trap_i,
    input wire logic [3:0] instr_addr_match_i,
    input wire logic return_i,
    input wire logic return_critical_i,
    input wire logic data_acc_valid_i,
    input wire logic data_acc_store_i,
    input wire logic [31:0] data_acc_addr_i,
    input wire logic debug_status_event_set_i,
    // results
    output logic external_debug_o,
    output logic internal_debug_o,
    output logic reset_req_o,
    output logic [1:0] reset_kind_o,
    output logic completion_event_o,
    output logic branch_event_o,
    output logic interrupt_event_o,
    output logic trap_event_o,
    output logic [3:0] instr_addr_event_o,
    output logic data_watch1_load_event_o,
    output logic data_watch1_store_event_o,
    output logic data_watch2_load_event_o,
    output logic data_watch2_store_event_o,
    output logic return_event_o,
    output logic freeze_timers_o
);

    // ----------------------------------------------------------------
    // register port decode
    // ----------------------------------------------------------------
    logic [31:0] ctrl_r; // stored control bits, reset field never held
    wire logic [31:0] watch1_addr; // watch register one contents
    wire logic [31:0] watch2_addr; // watch register two contents
    wire logic sel_ctrl; // number hits the control word
    wire logic sel_w1;
    wire logic sel_w2;
    wire logic mapped;
    wire logic allowed; // supervisor access only
    wire logic wr_ok; // a write that takes effect
    wire logic wr_ctrl;
    wire logic wr_w1;
    wire logic wr_w2;
    wire logic [31:0] rd_mux; // read data before the output flop
    wire logic [31:0] ctrl_nxt;
    wire logic [1:0] rst_field; // reset code carried by a control write

    assign sel_ctrl = (spr_num_i == SPR_DEBUG_CONTROL_ZERO);
    assign sel_w1 = (spr_num_i == SPR_DATA_WATCH_ONE);
    assign sel_w2 = (spr_num_i == SPR_DATA_WATCH_TWO);
    assign mapped = sel_ctrl | sel_w1 | sel_w2;
    // user-state accesses are refused whole: no store, zero read data
    assign allowed = spr_req_i & supervisor_i & mapped;
    assign wr_ok = allowed & spr_write_i;
    assign wr_ctrl = wr_ok & sel_ctrl;
    assign wr_w1 = wr_ok & sel_w1;
    assign wr_w2 = wr_ok & sel_w2;

    // reserved and reset-field bits are masked out of the stored word
    assign ctrl_nxt = wr_ctrl ? (spr_wdata_i & CTRL_STORE_MASK) : ctrl_r;
    assign rst_field = {spr_wdata_i[RST_HI_POS], spr_wdata_i[RST_LO_POS]};

    // read data: reserved bits and the reset field always read zero
    assign rd_mux = !(allowed & ~spr_write_i) ? READ_ZERO :
                    sel_ctrl ? ctrl_r :
                    sel_w1 ? watch1_addr :
                    watch2_addr;

    // ----------------------------------------------------------------
    // mode and gating terms
    // ----------------------------------------------------------------
    wire logic ext_mode; // external debug mode on
    wire logic int_mode; // internal debug mode on
    wire logic any_mode;
    wire logic override; // external or wait mode lifts internal gating
    wire logic trace_blocked; // internal mode with trace allowance off
    wire logic crit_blocked; // internal mode alone
    wire logic completion_nxt;
    wire logic branch_nxt;
    wire logic interrupt_nxt;
    wire logic trap_nxt;
    wire logic [3:0] iac_nxt;
    wire logic return_nxt;
    wire logic freeze_nxt;

    assign ext_mode = ctrl_r[EXT_DEBUG_POS];
    assign int_mode = ctrl_r[INT_DEBUG_POS];
    // events are only meaningful while some debug mode is on
    assign any_mode = ext_mode | int_mode | debug_wait_i;
    assign override = ext_mode | debug_wait_i;
    assign trace_blocked = int_mode & ~machine_state_trace_allow_i & ~override;
    assign crit_blocked = int_mode & ~override;

    assign completion_nxt = instr_complete_i & ctrl_r[COMPLETION_POS] & any_mode &
                            ~trace_blocked;
    assign branch_nxt = branch_taken_i & ctrl_r[BRANCH_POS] & any_mode &
                        ~trace_blocked;
    // critical interrupts are blocked in internal mode even with trace allowed
    assign interrupt_nxt = interrupt_i & ctrl_r[INTERRUPT_POS] & any_mode &
                           ~(interrupt_critical_i & crit_blocked);
    assign trap_nxt = trap_i & ctrl_r[TRAP_POS] & any_mode;
    // comparator 1 takes the highest enable bit, comparator 4 the lowest
    assign iac_nxt = {instr_addr_match_i[0], instr_addr_match_i[1],
                      instr_addr_match_i[2], instr_addr_match_i[3]} &
                     ctrl_r[IAC_HI_POS:IAC_LO_POS] & {4{any_mode}};
    // only the critical returns are trace-gated
    assign return_nxt = return_i & ctrl_r[RETURN_POS] & any_mode &
                        ~(return_critical_i & trace_blocked);
    assign freeze_nxt = ctrl_r[FREEZE_POS] & debug_status_event_set_i;

    // ----------------------------------------------------------------
    // control word and port answer
    // ----------------------------------------------------------------
    // control word storage and one-cycle access answer
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ctrl_r <= CTRL_RESET;
            spr_ack_o <= 1'b0;
            spr_denied_o <= 1'b0;
            spr_rdata_o <= READ_ZERO;
        end else begin
            ctrl_r <= ctrl_nxt;
            spr_ack_o <= spr_req_i;
            spr_denied_o <= spr_req_i & mapped & ~supervisor_i;
            spr_rdata_o <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // reset request
    // ----------------------------------------------------------------
    // any nonzero code pulses the request once; the code is held for the
    // reset controller, which needs it after the pulse has gone
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            reset_req_o <= 1'b0;
            reset_kind_o <= RST_NONE;
        end else begin
            reset_req_o <= wr_ctrl & (rst_field != RST_NONE);
            if (wr_ctrl & (rst_field != RST_NONE)) begin
                reset_kind_o <= rst_field;
            end
        end
    end

    // ----------------------------------------------------------------
    // event and mode outputs
    // ----------------------------------------------------------------
    // one-cycle event pulses, one edge after the pipeline pulse
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            external_debug_o <= 1'b0;
            internal_debug_o <= 1'b0;
            completion_event_o <= 1'b0;
            branch_event_o <= 1'b0;
            interrupt_event_o <= 1'b0;
            trap_event_o <= 1'b0;
            instr_addr_event_o <= 4'h0;
            return_event_o <= 1'b0;
            freeze_timers_o <= 1'b0;
        end else begin
            external_debug_o <= ctrl_nxt[EXT_DEBUG_POS];
            internal_debug_o <= ctrl_nxt[INT_DEBUG_POS];
            completion_event_o <= completion_nxt;
            branch_event_o <= branch_nxt;
            interrupt_event_o <= interrupt_nxt;
            trap_event_o <= trap_nxt;
            instr_addr_event_o <= iac_nxt;
            return_event_o <= return_nxt;
            freeze_timers_o <= freeze_nxt;
        end
    end

    // ----------------------------------------------------------------
    // data watch comparators
    // ----------------------------------------------------------------
    data_watch_unit watch_one (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(wr_w1),
        .wr_data_i(spr_wdata_i),
        .acc_valid_i(data_acc_valid_i),
        .acc_store_i(data_acc_store_i),
        .acc_addr_i(data_acc_addr_i),
        .load_enable_i(ctrl_r[WATCH1_LOAD_POS] & any_mode),
        .store_enable_i(ctrl_r[WATCH1_STORE_POS] & any_mode),
        .addr_o(watch1_addr),
        .load_hit_o(data_watch1_load_event_o),
        .store_hit_o(data_watch1_store_event_o)
    );

    data_watch_unit watch_two (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(wr_w2),
        .wr_data_i(spr_wdata_i),
        .acc_valid_i(data_acc_valid_i),
        .acc_store_i(data_acc_store_i),
        .acc_addr_i(data_acc_addr_i),
        .load_enable_i(ctrl_r[WATCH2_LOAD_POS] & any_mode),
        .store_enable_i(ctrl_r[WATCH2_STORE_POS] & any_mode),
        .addr_o(watch2_addr),
        .load_hit_o(data_watch2_load_event_o),
        .store_hit_o(data_watch2_store_event_o)
    );

endmodule

`default_nettype wire

/* File: pkg/debug_event_pkg.sv */
// package for the debug event control block: register numbers, field
// positions, reset values and reset request codes.
// assumes a 32-bit special register port with a 10-bit register number.
`default_nettype none

package debug_event_pkg;

    // ----------------------------------------------------------------
    // special register numbers
    // ----------------------------------------------------------------
    localparam logic [9:0] SPR_DEBUG_CONTROL_ZERO = 10'h134; // control word
    localparam logic [9:0] SPR_DATA_WATCH_ONE = 10'h13C; // watch address one
    localparam logic [9:0] SPR_DATA_WATCH_TWO = 10'h13D; // watch address two

    // ----------------------------------------------------------------
    // control word fields; the documented bit n sits at vector bit 31-n
    // ----------------------------------------------------------------
    localparam int EXT_DEBUG_POS = 31; // documented bit 0
    localparam int INT_DEBUG_POS = 30; // documented bit 1
    localparam int RST_HI_POS = 29; // documented bits 2:3
    localparam int RST_LO_POS = 28;
    localparam int COMPLETION_POS = 27; // documented bit 4
    localparam int BRANCH_POS = 26; // documented bit 5
    localparam int INTERRUPT_POS = 25; // documented bit 6
    localparam int TRAP_POS = 24; // documented bit 7
    localparam int IAC_HI_POS = 23; // comparator 1, documented bit 8
    localparam int IAC_LO_POS = 20; // comparator 4, documented bit 11
    localparam int WATCH1_LOAD_POS = 19; // documented bit 12
    localparam int WATCH1_STORE_POS = 18; // documented bit 13
    localparam int WATCH2_LOAD_POS = 17; // documented bit 14
    localparam int WATCH2_STORE_POS = 16; // documented bit 15
    localparam int RETURN_POS = 15; // documented bit 16
    localparam int FREEZE_POS = 0; // documented bit 31

    // stored bits: everything except the reset field and the reserved span
    localparam logic [31:0] CTRL_STORE_MASK = 32'hCFFF8001;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [31:0] WATCH_RESET = 32'h00000000;
    localparam logic [31:0] READ_ZERO = 32'h00000000;

    // ----------------------------------------------------------------
    // reset request codes
    // ----------------------------------------------------------------
    localparam logic [1:0] RST_NONE = 2'h0;
    localparam logic [1:0] RST_CORE = 2'h1;
    localparam logic [1:0] RST_CHIP = 2'h2;
    localparam logic [1:0] RST_SYSTEM = 2'h3;

endpackage

`default_nettype wire

/* File: hdl/data_watch_unit.sv */
// one data watch address register with its byte address comparator.
// assumes load/store attempts arrive on the core clock, one per cycle.
`default_nettype none

module data_watch_unit
    import debug_event_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [31:0] wr_data_i,
    input wire logic acc_valid_i,
    input wire logic acc_store_i,
    input wire logic [31:0] acc_addr_i,
    input wire logic load_enable_i,
    input wire logic store_enable_i,
    output logic [31:0] addr_o,
    output logic load_hit_o,
    output logic store_hit_o
);

    // ----------------------------------------------------------------
    // compare
    // ----------------------------------------------------------------
    wire logic addr_equal; // full byte address match, no masking
    wire logic load_hit_nxt;
    wire logic store_hit_nxt;

    assign addr_equal = (acc_addr_i == addr_o);
    assign load_hit_nxt = acc_valid_i & ~acc_store_i & addr_equal & load_enable_i;
    assign store_hit_nxt = acc_valid_i & acc_store_i & addr_equal & store_enable_i;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    // address register and registered hit pulses
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            addr_o <= WATCH_RESET;
            load_hit_o <= 1'b0;
            store_hit_o <= 1'b0;
        end else begin
            if (wr_en_i) begin
                addr_o <= wr_data_i;
            end
            load_hit_o <= load_hit_nxt;
            store_hit_o <= store_hit_nxt;
        end
    end

endmodule

`default_nettype wire

/* File: testbench/debug_event_chk.sv */
// checker: port timing of the debug event control block.
// assumes it is bound onto debug_event_control and sees its ports only.
`default_nettype none

module debug_event_chk (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic spr_req_i,
    input wire logic spr_write_i,
    input wire logic [9:0] spr_num_i,
    input wire logic [31:0] spr_wdata_i,
    input wire logic supervisor_i,
    input wire logic spr_ack_o,
    input wire logic spr_denied_o,
    input wire logic [31:0] spr_rdata_o,
    input wire logic machine_state_trace_allow_i,
    input wire logic debug_wait_i,
    input wire logic branch_taken_i,
    input wire logic interrupt_i,
    input wire logic interrupt_critical_i,
    input wire logic trap_i,
    input wire logic debug_status_event_set_i,
    input wire logic external_debug_o,
    input wire logic internal_debug_o,
    input wire logic reset_req_o,
    input wire logic [1:0] reset_kind_o,
    input wire logic branch_event_o,
    input wire logic interrupt_event_o,
    input wire logic trap_event_o,
    input wire logic freeze_timers_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // ----------------------------------------------------------------
    // helpers: control word write, mapped number, internal mode alone
    // ----------------------------------------------------------------
    wire logic ctrl_wr = spr_req_i && spr_write_i && supervisor_i && spr_num_i == 10'h134;
    wire logic mapped = spr_num_i inside {10'h134, 10'h13C, 10'h13D};
    wire logic int_only = internal_debug_o && !external_debug_o && !debug_wait_i;
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    chk_ack_next: assert property (spr_req_i |=> spr_ack_o)
        else $error("register access not acknowledged next cycle");
    chk_ack_cause: assert property (spr_ack_o |-> $past(spr_req_i))
        else $error("acknowledge without a request");
    chk_user_denied: assert property (spr_req_i && !supervisor_i && mapped |=>
        spr_denied_o && spr_rdata_o == 32'h00000000) else $error("user access not refused");
    chk_mode_mirror: assert property (ctrl_wr |=> external_debug_o == $past(spr_wdata_i[31])
        && internal_debug_o == $past(spr_wdata_i[30])) else $error("mode bits not applied");
    chk_reset_pulse: assert property (ctrl_wr && spr_wdata_i[29:28] != 2'h0 |=>
        reset_req_o && reset_kind_o == $past(spr_wdata_i[29:28])) else $error("reset missing");
    chk_reset_cause: assert property (reset_req_o |-> $past(ctrl_wr))
        else $error("reset request without a control write");
    chk_reserved_zero: assert property (spr_req_i && !spr_write_i && spr_num_i == 10'h134 |=>
        spr_rdata_o[14:1] == 14'h0000 && spr_rdata_o[29:28] == 2'h0) else $error("reserved set");
    chk_trap_nomode: assert property (trap_i && !external_debug_o && !internal_debug_o
        && !debug_wait_i |=> !trap_event_o) else $error("trap event with no mode active");
    chk_crit_block: assert property (interrupt_i && interrupt_critical_i && int_only
        |=> !interrupt_event_o) else $error("critical interrupt raised an event");
    chk_branch_gate: assert property (branch_taken_i && int_only && !machine_state_trace_allow_i
        |=> !branch_event_o) else $error("branch event while trace disallowed");
    chk_freeze_cause: assert property (freeze_timers_o |-> $past(debug_status_event_set_i))
        else $error("timers frozen with no status set");
    // main scenarios reached
    cover property (ctrl_wr && spr_wdata_i[29:28] == 2'h3);
    cover property (interrupt_i && interrupt_critical_i && int_only);
    cover property (spr_denied_o);
endmodule

`default_nettype wire

/* File: testbench/pipeline_model.sv */
// partner: pipeline that turns a random word into one cycle of pulses.
// assumes go_i is raised for one cycle; pulses appear in the next cycle.
`default_nettype none

module pipeline_model (
    input wire logic ref_clk_i,
    input wire logic go_i,
    input wire logic [31:0] rnd_i,
    input wire logic [31:0] watch1_i,
    input wire logic [31:0] watch2_i,
    output logic [12:0] pulse_o = 13'h0000,
    output logic [31:0] addr_o = 32'h00000000
);
    timeunit 1ns;
    timeprecision 100ps;
    // pulses last one cycle only; the address is aimed at a watch
    // register half the time so matches are common, and is fresh otherwise
    always @(posedge ref_clk_i) begin
        pulse_o <= go_i ? rnd_i[12:0] : 13'h0000;
        case (rnd_i[14:13])
            2'h0: addr_o <= watch1_i;
            2'h1: addr_o <= watch2_i;
            default: addr_o <= rnd_i ^ addr_o;
        endcase
    end
endmodule

`default_nettype wire

/* File: testbench/tb_top.sv */
// testbench top: register port and pipeline traffic against a bench model.
// assumes the package, design, checker and pipeline model compile first.
`default_nettype none

module tb_top;
    import debug_event_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, spr_req_i = 1'b0, spr_write_i = 1'b0;
    logic supervisor_i = 1'b0, allow = 1'b0, dwait = 1'b0, dstat = 1'b0, go = 1'b0;
    logic [9:0] spr_num_i = 10'h000;
    logic [31:0] spr_wdata_i = 32'h0, rnd = 32'h0, seed = 32'h6, exp_rd;
    logic [31:0] ctrl = 32'h0, w1 = 32'h0, w2 = 32'h0; // bench model registers
    logic [1:0] kind_m = 2'h0;
    int error_cnt = 0, samples_checked = 0;
    wire [31:0] rdata, acc_addr;
    wire [12:0] ev, p;
    wire [1:0] kind;
    wire ack, den, rreq, fz, ext, intd;

    debug_event_control DUT (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .spr_req_i(spr_req_i),
        .spr_write_i(spr_write_i), .spr_num_i(spr_num_i), .spr_wdata_i(spr_wdata_i),
        .supervisor_i(supervisor_i), .spr_ack_o(ack), .spr_denied_o(den), .spr_rdata_o(rdata),
        .machine_state_trace_allow_i(allow), .debug_wait_i(dwait), .instr_complete_i(p[0]),
        .branch_taken_i(p[1]), .interrupt_i(p[2]), .interrupt_critical_i(p[3]), .trap_i(p[4]),
        .instr_addr_match_i(p[8:5]), .data_acc_valid_i(p[9]), .data_acc_store_i(p[10]),
        .data_acc_addr_i(acc_addr), .return_i(p[11]), .return_critical_i(p[12]),
        .debug_status_event_set_i(dstat), .external_debug_o(ext), .internal_debug_o(intd),
        .reset_req_o(rreq), .reset_kind_o(kind), .completion_event_o(ev[0]),
        .branch_event_o(ev[1]), .interrupt_event_o(ev[2]), .trap_event_o(ev[3]),
        .instr_addr_event_o(ev[7:4]), .data_watch1_load_event_o(ev[8]),
        .data_watch1_store_event_o(ev[9]), .data_watch2_load_event_o(ev[10]),
        .data_watch2_store_event_o(ev[11]), .return_event_o(ev[12]), .freeze_timers_o(fz));

    pipeline_model partner (.ref_clk_i(ref_clk_i), .go_i(go), .rnd_i(rnd), .watch1_i(w1),
        .watch2_i(w2), .pulse_o(p), .addr_o(acc_addr));

    // xorshift source, fixed start so every run is the same
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one register access; request stays up so accesses can run back to back
    task automatic spr(input logic wr, input logic [9:0] num, input logic [31:0] d,
                       input logic sup);
        logic mapped;
        logic rq;
        mapped = num inside {SPR_DEBUG_CONTROL_ZERO, SPR_DATA_WATCH_ONE, SPR_DATA_WATCH_TWO};
        exp_rd = num == SPR_DATA_WATCH_ONE ? w1 : num == SPR_DATA_WATCH_TWO ? w2 : ctrl;
        exp_rd = (sup && mapped && !wr) ? exp_rd & (num == SPR_DEBUG_CONTROL_ZERO ?
                 CTRL_STORE_MASK : 32'hFFFFFFFF) : 32'h0;
        rq = wr && sup && num == SPR_DEBUG_CONTROL_ZERO && d[29:28] != 2'h0;
        spr_req_i = 1'b1;
        spr_write_i = wr;
        spr_num_i = num;
        spr_wdata_i = d;
        supervisor_i = sup;
        @(posedge ref_clk_i);
        #1;
        if (wr && sup && num == SPR_DEBUG_CONTROL_ZERO) ctrl = d;
        if (wr && sup && num == SPR_DATA_WATCH_ONE) w1 = d;
        if (wr && sup && num == SPR_DATA_WATCH_TWO) w2 = d;
        if (rq) kind_m = d[29:28];
        check({ack, den, rdata}, {1'b1, !sup && mapped, exp_rd});
        check({rreq, kind, ext, intd}, {rq, kind_m, ctrl[31:30]});
    endtask

    // one random burst of pipeline pulses, then compare every event output
    task automatic ev_step();
        logic e, i, md, gate, ld, st;
        logic [12:0] x;
        spr_req_i = 1'b0;
        rnd = xs();
        allow = rnd[20];
        dwait = rnd[21] & rnd[22];
        dstat = rnd[23];
        go = 1'b1;
        @(posedge ref_clk_i);
        #1;
        go = 1'b0;
        e = ctrl[31];
        i = ctrl[30];
        md = e | i | dwait;
        gate = md & !(i & !allow & !e & !dwait);
        ld = p[9] & !p[10] & md;
        st = p[9] & p[10] & md;
        x[0] = p[0] & ctrl[27] & gate;
        x[1] = p[1] & ctrl[26] & gate;
        x[2] = p[2] & ctrl[25] & md & !(p[3] & i & !e & !dwait);
        x[3] = p[4] & ctrl[24] & md;
        // event bit 7 carries comparator 1 (match bit 0, enable at vector bit 23)
        x[7:4] = {p[5], p[6], p[7], p[8]} & ctrl[23:20] & {4{md}};
        x[8] = ld & acc_addr == w1 & ctrl[19];
        x[9] = st & acc_addr == w1 & ctrl[18];
        x[10] = ld & acc_addr == w2 & ctrl[17];
        x[11] = st & acc_addr == w2 & ctrl[16];
        x[12] = p[11] & ctrl[15] & (p[12] ? gate : md);
        @(posedge ref_clk_i);
        #1;
        check({23'h0, ev}, {23'h0, x});
        check({35'h0, fz}, {35'h0, ctrl[0] & dstat});
    endtask

    task automatic test_done();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // about 1000 cycles are needed; twenty times that means a hang
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        error_cnt++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge ref_clk_i);
        #1;
        rst_n_i = 1'b1;
        @(posedge ref_clk_i);
        #1;
        spr(1'b0, SPR_DEBUG_CONTROL_ZERO, 32'h0, 1'b1);
        spr(1'b0, SPR_DATA_WATCH_ONE, 32'h0, 1'b1);
        spr(1'b0, SPR_DATA_WATCH_TWO, 32'h0, 1'b1);
        spr(1'b1, SPR_DATA_WATCH_ONE, 32'hA5A5F00F, 1'b0);
        spr(1'b0, SPR_DATA_WATCH_ONE, 32'h0, 1'b0);
        spr(1'b1, 10'h135, 32'hFFFFFFFF, 1'b1);
        spr(1'b0, 10'h135, 32'h0, 1'b1);
        for (int k = 0; k < 4; k++) begin
            spr(1'b1, SPR_DEBUG_CONTROL_ZERO, {2'h3, k[1:0], 28'hFFFFFFF}, 1'b1);
            spr(1'b0, SPR_DEBUG_CONTROL_ZERO, 32'h0, 1'b1);
        end
        for (int n = 0; n < 400; n++) begin
            if (n % 8 == 0) begin
                spr(1'b1, SPR_DEBUG_CONTROL_ZERO, xs(), 1'b1);
                spr(1'b1, SPR_DATA_WATCH_ONE, xs(), 1'b1);
                spr(1'b1, SPR_DATA_WATCH_TWO, xs(), 1'b1);
                spr(1'b0, SPR_DATA_WATCH_TWO, 32'h0, 1'b1);
            end
            ev_step();
        end
        test_done();
    end
endmodule

bind debug_event_control debug_event_chk chk_i (.*);

`default_nettype wire
